// ---- kbtr_gate_seq.sv ----
// kbtr_gate_seq: recognises the address-line gate command sequence on ports 60h and 64h
// assumes: access_valid_i is a one-cycle pulse per decoded host cycle, synchronous to clk_i
`timescale 1ns/1ps
module kbtr_gate_seq (
    input wire logic clk_i,           // core clock
    input wire logic reset_i,         // synchronous reset, active high
    input wire logic access_valid_i,  // one decoded port access this cycle
    input wire logic access_port64_i, // 1: port 64h, 0: port 60h
    input wire logic access_write_i,  // 1: write, 0: read
    input wire logic [7:0] access_data_i, // write data of the access
    output logic force_pass_o,        // access passed untrapped
    output logic normal_trap_o,       // access follows its own enable
    output logic seq_end_o,           // sequence ended, seq end enable decides interrupt
    output logic passthrough_o        // pass-through state flag
);

    typedef struct packed {
        kbtr_pkg::kbtr_gate_t state;
    } kbtr_seq_state_t;

    kbtr_seq_state_t r;
    kbtr_seq_state_t next_r;

    logic wr60;
    logic rd60;
    logic wr64;
    logic rd64;

    assign wr60 = access_valid_i && !access_port64_i && access_write_i;
    assign rd60 = access_valid_i && !access_port64_i && !access_write_i;
    assign wr64 = access_valid_i && access_port64_i && access_write_i;
    assign rd64 = access_valid_i && access_port64_i && !access_write_i;

    always_comb begin
        next_r = r;
        force_pass_o = 1'b0;
        normal_trap_o = access_valid_i;
        seq_end_o = 1'b0;
        case (r.state)
            kbtr_pkg::GATE_IDLE: begin
                if (wr64 && access_data_i == kbtr_pkg::GATE_CMD) begin
                    force_pass_o = 1'b1;
                    normal_trap_o = 1'b0;
                    next_r.state = kbtr_pkg::GATE_SEQ_FIRST;
                end
                // any other access stays idle and follows its enable
            end
            kbtr_pkg::GATE_SEQ_FIRST: begin
                if (wr60) begin
                    force_pass_o = 1'b1;
                    normal_trap_o = 1'b0;
                    next_r.state = kbtr_pkg::GATE_SEQ_SECOND;
                end else if (wr64 && access_data_i == kbtr_pkg::GATE_CMD) begin
                    force_pass_o = 1'b1;
                    normal_trap_o = 1'b0;
                end else if (wr64 || rd60) begin
                    seq_end_o = 1'b1;
                    next_r.state = kbtr_pkg::GATE_IDLE;
                end
                // a port 64h read keeps the state
            end
            kbtr_pkg::GATE_SEQ_SECOND: begin
                if (wr64 && access_data_i == kbtr_pkg::GATE_END) begin
                    force_pass_o = 1'b1;
                    normal_trap_o = 1'b0;
                    seq_end_o = 1'b1;
                    next_r.state = kbtr_pkg::GATE_IDLE;
                end else if (wr64 || wr60 || rd60) begin
                    seq_end_o = 1'b1;
                    next_r.state = kbtr_pkg::GATE_IDLE;
                end
                // a port 64h read keeps the state
            end
            default: begin
                next_r.state = kbtr_pkg::GATE_IDLE;
            end
        endcase
    end

    // flag is 1 exactly while inside the sequence
    assign passthrough_o = (r.state != kbtr_pkg::GATE_IDLE);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r.state <= kbtr_pkg::GATE_IDLE;
        end else begin
            r <= next_r;
        end
    end

endmodule

// ---- kbtr_host_model.sv ----
// kbtr_host_model: host bus master issuing one port cycle at a time to the trap
// assumes: the cycle ends on the trap's ready pulse; keyboard select is watched meanwhile
`timescale 1ns/1ps
module kbtr_host_model (
    input wire logic clk_i,        // clock
    input wire logic reset_i,      // reset
    input wire logic req_i,        // start a cycle
    input wire logic [1:0] kind_i, // b1 port 64h, b0 write
    input wire logic [7:0] data_i, // write data
    input wire logic ready_i,      // cycle may end
    input wire logic cs_n_i,       // controller select
    output logic valid_o,          // access pulse
    output logic port64_o,         // port 64h
    output logic write_o,          // write
    output logic [7:0] data_o,     // data
    output logic done_o,           // cycle ended
    output logic passed_o          // select seen
);
    logic busy;
    initial {busy, valid_o, port64_o, write_o, data_o, done_o, passed_o} = '0;
    always @(posedge clk_i) begin
        valid_o <= 1'h0;
        done_o <= 1'h0;
        if (reset_i) begin
            busy <= 1'h0;
            passed_o <= 1'h0;
        end else if (req_i && !busy) begin
            valid_o <= 1'h1;
            busy <= 1'h1;
            passed_o <= 1'h0;
            {port64_o, write_o, data_o} <= {kind_i, data_i};
        end else begin
            // released lines show the inverse, never a stale value
            if (valid_o) begin
                {port64_o, write_o, data_o} <= ~{port64_o, write_o, data_o};
            end
            if (busy && !cs_n_i) passed_o <= 1'h1;
            if (busy && ready_i) begin
                busy <= 1'h0;
                done_o <= 1'h1;
            end
        end
    end
endmodule

// ---- kbtr_legacy_kbd_trap.sv ----
// kbtr_legacy_kbd_trap: snoop and trap of host accesses to keyboard controller ports 60h/64h
// assumes: host cycle decode gives one valid pulse per access at least two cycles
// before the cycle may end; target ready is held off until TARGET_READY_O
//
// Notes on behaviour
// - each of port 60 read, port 60 write, port 64 read and port 64 write latches its own readable status bit.
// - status latches regardless of enable, and the interrupt is the OR of each status ANDed with its enable.
// - a trapped access drives the interrupt active before target ready may go active for that cycle.
// - the keyboard controller select is withheld for an enabled access unless the gate sequence passes it.
// - in idle a D1h write to port 64h passes through with no interrupt, enters the first gate state and sets the flag.
// - in idle every other access stays idle and follows enable bits 3, 2, 1 and 0 for 64W, 64R, 60W and 60R.
// - in the first gate state any port 60h write passes with no interrupt and enters the second gate state.
// - in the first gate state a repeated D1h write to port 64h passes with no interrupt and stays there.
// - in the first gate state another port 64h write returns to idle, clears the flag, follows bit 3, and bit 7 adds an interrupt.
// - in the first gate state a port 60h read returns to idle, clears the flag, follows bit 0, and bit 7 adds an interrupt.
// - in either gate state a port 64h read keeps state and flag and interrupts only if bit 2 is set.
// - in the second gate state an FFh write to port 64h passes, returns to idle, clears the flag, and bit 7 decides the interrupt.
// - in the second gate state any other write or a port 60h read returns to idle, clears the flag, follows its bit, and bit 7 adds an interrupt.
`timescale 1ns/1ps
module kbtr_legacy_kbd_trap #(
    parameter int ADDR_W = 8,  // register port address width
    parameter int DATA_W = 8   // register port data width
) (
    input wire logic CORE_CLK_I,         // core clock, 100 MHz
    input wire logic RESET_I,            // synchronous reset, active high
    input wire logic ACCESS_VALID_I,     // one-cycle pulse per decoded port access
    input wire logic ACCESS_PORT64_I,    // 1: port 64h, 0: port 60h
    input wire logic ACCESS_WRITE_I,     // 1: write, 0: read
    input wire logic [7:0] ACCESS_DATA_I, // host write data
    input wire logic USB_IRQ_I,          // host controller interrupt request, level
    input wire logic [ADDR_W-1:0] REG_ADDR_I, // register address
    input wire logic [DATA_W-1:0] REG_WDATA_I, // register write data
    input wire logic REG_WR_I,           // register write strobe
    input wire logic REG_RD_I,           // register read strobe
    output logic [DATA_W-1:0] REG_RDATA_O, // read data, cycle after strobe
    output logic KBC_CS_N_O,             // keyboard controller select, active low pulse
    output logic TARGET_READY_O,         // cycle may complete, one-cycle pulse
    output logic SYSTEM_MGMT_INTERRUPT_N_O, // management interrupt, active low level
    output logic SHARED_IRQ_LINE_D_N_O,  // shared interrupt line, active low level
    output logic PASSTHROUGH_STATE_FLAG_O // pass-through flag
);

    // refuse widths the byte-wide register map cannot serve
    if (DATA_W != 8) begin : g_bad_data_w
        $error("kbtr_legacy_kbd_trap: DATA_W must be 8");
    end
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("kbtr_legacy_kbd_trap: ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic [7:0] cfg;
        logic [kbtr_pkg::ST_W-1:0] status;
        logic [DATA_W-1:0] rdata;
        logic cs_n;
        logic ready_wait;
        logic ready;
        logic smi_n;
        logic irq_n;
        logic flag;
    } kbtr_trap_state_t;

    kbtr_trap_state_t r;
    kbtr_trap_state_t next_r;

    logic force_pass;
    logic normal_trap;
    logic seq_end;
    logic passthrough;

    kbtr_gate_seq u_gate_seq (
        .clk_i(CORE_CLK_I),
        .reset_i(RESET_I),
        .access_valid_i(ACCESS_VALID_I),
        .access_port64_i(ACCESS_PORT64_I),
        .access_write_i(ACCESS_WRITE_I),
        .access_data_i(ACCESS_DATA_I),
        .force_pass_o(force_pass),
        .normal_trap_o(normal_trap),
        .seq_end_o(seq_end),
        .passthrough_o(passthrough)
    );

    // one-hot kind of an access, bit positions match enables and status
    function automatic logic [3:0] access_kind(input logic valid, input logic port64,
                                               input logic write);
        logic [3:0] kind;
        kind = 4'h0;
        if (valid) begin
            kind[kbtr_pkg::ST_P60_READ] = !port64 && !write;
            kind[kbtr_pkg::ST_P60_WRITE] = !port64 && write;
            kind[kbtr_pkg::ST_P64_READ] = port64 && !write;
            kind[kbtr_pkg::ST_P64_WRITE] = port64 && write;
        end
        return kind;
    endfunction

    // enables of the status bits, laid out like the status register
    function automatic logic [kbtr_pkg::ST_W-1:0] status_mask(input logic [7:0] cfg);
        logic [kbtr_pkg::ST_W-1:0] m;
        m = '0;
        m[kbtr_pkg::ST_P60_READ] = cfg[kbtr_pkg::CFG_EN_P60_READ];
        m[kbtr_pkg::ST_P60_WRITE] = cfg[kbtr_pkg::CFG_EN_P60_WRITE];
        m[kbtr_pkg::ST_P64_READ] = cfg[kbtr_pkg::CFG_EN_P64_READ];
        m[kbtr_pkg::ST_P64_WRITE] = cfg[kbtr_pkg::CFG_EN_P64_WRITE];
        m[kbtr_pkg::ST_IRQ] = cfg[kbtr_pkg::CFG_IRQ_TRAP_EN];
        m[kbtr_pkg::ST_SEQ_END] = cfg[kbtr_pkg::CFG_SEQ_END_EN];
        return m;
    endfunction

    logic [3:0] kind;
    logic [3:0] kind_en;
    logic [kbtr_pkg::ST_W-1:0] set_bits;
    logic [kbtr_pkg::ST_W-1:0] clr_bits;
    logic hit_cfg;
    logic hit_status;

    assign kind = access_kind(ACCESS_VALID_I, ACCESS_PORT64_I, ACCESS_WRITE_I);
    assign kind_en = r.cfg[3:0];
    assign hit_cfg = (REG_ADDR_I[7:0] == kbtr_pkg::CFG_OFFSET) && (REG_ADDR_I >> 8) == '0;
    assign hit_status = (REG_ADDR_I[7:0] == kbtr_pkg::STATUS_OFFSET) && (REG_ADDR_I >> 8) == '0;

    always_comb begin
        next_r = r;
        set_bits = '0;
        clr_bits = '0;

        // access kind status latches whenever normal handling applies
        if (normal_trap) begin
            set_bits[3:0] = kind;
        end
        if (seq_end) begin
            set_bits[kbtr_pkg::ST_SEQ_END] = 1'b1;
        end
        if (USB_IRQ_I) begin
            set_bits[kbtr_pkg::ST_IRQ] = 1'b1;
        end

        // register writes
        if (REG_WR_I && hit_cfg) begin
            next_r.cfg = REG_WDATA_I & kbtr_pkg::CFG_WRITABLE;
        end
        if (REG_WR_I && hit_status) begin
            clr_bits = REG_WDATA_I[kbtr_pkg::ST_W-1:0];
        end
        // a new event in the clearing cycle is kept
        next_r.status = (r.status & ~clr_bits) | set_bits;

        // read data, only in the cycle after the strobe
        next_r.rdata = '0;
        if (REG_RD_I) begin
            if (hit_cfg) begin
                next_r.rdata = r.cfg;
                next_r.rdata[kbtr_pkg::CFG_PASSTHROUGH] = passthrough;
            end else if (hit_status) begin
                next_r.rdata = {{(DATA_W - kbtr_pkg::ST_W){1'b0}}, r.status};
            end else begin
                next_r.rdata = kbtr_pkg::RDATA_UNMAPPED;
            end
        end

        // select goes active for passed accesses only
        next_r.cs_n = !(ACCESS_VALID_I
                        && (force_pass || (normal_trap && !(|(kind & kind_en)))));

        // interrupt from latched status gated by enables
        next_r.smi_n = !(|(next_r.status & status_mask(next_r.cfg)));
        next_r.irq_n = !(next_r.status[kbtr_pkg::ST_IRQ]
                         && next_r.cfg[kbtr_pkg::CFG_IRQ_ROUTE_EN]);

        // target ready a cycle after the interrupt is already driven
        next_r.ready_wait = ACCESS_VALID_I;
        next_r.ready = r.ready_wait;

        next_r.flag = passthrough;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            r.cfg <= kbtr_pkg::CFG_RESET;
            r.status <= kbtr_pkg::ST_RESET;
            r.rdata <= '0;
            r.cs_n <= 1'b1;
            r.ready_wait <= 1'b0;
            r.ready <= 1'b0;
            r.smi_n <= 1'b1;
            r.irq_n <= 1'b1;
            r.flag <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign REG_RDATA_O = r.rdata;
    assign KBC_CS_N_O = r.cs_n;
    assign TARGET_READY_O = r.ready;
    assign SYSTEM_MGMT_INTERRUPT_N_O = r.smi_n;
    assign SHARED_IRQ_LINE_D_N_O = r.irq_n;
    assign PASSTHROUGH_STATE_FLAG_O = r.flag;

endmodule

// ---- kbtr_legacy_kbd_trap_properties.sv ----
// kbtr_trap_props: port-level timing and gate sequence checks of the keyboard port trap
// assumes: bound to kbtr_legacy_kbd_trap; accesses at least three cycles apart
`timescale 1ns/1ps
module kbtr_trap_props #(
    parameter int ADDR_W = 8, // address width
    parameter int DATA_W = 8  // data width
) (
    input wire logic CORE_CLK_I,               // clock
    input wire logic RESET_I,                  // reset
    input wire logic ACCESS_VALID_I,           // access
    input wire logic ACCESS_PORT64_I,          // port 64h
    input wire logic ACCESS_WRITE_I,           // write
    input wire logic [7:0] ACCESS_DATA_I,      // data
    input wire logic USB_IRQ_I,                // irq request
    input wire logic [ADDR_W-1:0] REG_ADDR_I,  // address
    input wire logic [DATA_W-1:0] REG_WDATA_I, // write data
    input wire logic REG_WR_I,                 // write strobe
    input wire logic REG_RD_I,                 // read strobe
    input wire logic [DATA_W-1:0] REG_RDATA_O, // read data
    input wire logic KBC_CS_N_O,               // select
    input wire logic TARGET_READY_O,           // ready
    input wire logic SYSTEM_MGMT_INTERRUPT_N_O, // mgmt interrupt
    input wire logic SHARED_IRQ_LINE_D_N_O,    // shared line
    input wire logic PASSTHROUGH_STATE_FLAG_O  // flag
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    wire w64 = ACCESS_VALID_I && ACCESS_PORT64_I && ACCESS_WRITE_I;
    wire r64 = ACCESS_VALID_I && ACCESS_PORT64_I && !ACCESS_WRITE_I;
    wire r60 = ACCESS_VALID_I && !ACCESS_PORT64_I && !ACCESS_WRITE_I;
    wire d1 = w64 && (ACCESS_DATA_I == kbtr_pkg::GATE_CMD);
    a_ready_follows: assert property (ACCESS_VALID_I |-> ##2 TARGET_READY_O)
        else $error("ready missing after access");
    a_ready_caused: assert property (TARGET_READY_O |-> $past(ACCESS_VALID_I, 2))
        else $error("ready without access");
    a_trap_before_ready: assert property (TARGET_READY_O && $past(KBC_CS_N_O)
        |-> !SYSTEM_MGMT_INTERRUPT_N_O) else $error("trapped cycle ends without interrupt");
    a_select_caused: assert property (!KBC_CS_N_O |-> $past(ACCESS_VALID_I))
        else $error("select without access");
    a_select_single: assert property (!KBC_CS_N_O |=> KBC_CS_N_O)
        else $error("select longer than one cycle");
    a_gate_entry: assert property (d1 && !PASSTHROUGH_STATE_FLAG_O |=> !KBC_CS_N_O
        && $stable(SYSTEM_MGMT_INTERRUPT_N_O) ##1 PASSTHROUGH_STATE_FLAG_O)
        else $error("gate command not passed");
    a_read64_keeps: assert property (r64 |-> ##2
        PASSTHROUGH_STATE_FLAG_O == $past(PASSTHROUGH_STATE_FLAG_O, 2))
        else $error("port 64h read moved the flag");
    a_read60_idles: assert property (r60 |-> ##2 !PASSTHROUGH_STATE_FLAG_O)
        else $error("port 60h read left flag set");
    a_write64_idles: assert property (w64 && !d1 |-> ##2 !PASSTHROUGH_STATE_FLAG_O)
        else $error("port 64h write left flag set");
    a_rdata_quiet: assert property (!REG_RD_I |=> REG_RDATA_O == '0)
        else $error("read data outside read cycle");
    c_trapped: cover property (ACCESS_VALID_I ##1 KBC_CS_N_O ##1 TARGET_READY_O);
    c_gate: cover property (d1 ##2 PASSTHROUGH_STATE_FLAG_O);
    c_irq: cover property (USB_IRQ_I ##2 !SHARED_IRQ_LINE_D_N_O);
endmodule
bind kbtr_legacy_kbd_trap kbtr_trap_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
    .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .ACCESS_VALID_I(ACCESS_VALID_I),
    .ACCESS_PORT64_I(ACCESS_PORT64_I), .ACCESS_WRITE_I(ACCESS_WRITE_I),
    .ACCESS_DATA_I(ACCESS_DATA_I), .USB_IRQ_I(USB_IRQ_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .KBC_CS_N_O(KBC_CS_N_O), .TARGET_READY_O(TARGET_READY_O),
    .SYSTEM_MGMT_INTERRUPT_N_O(SYSTEM_MGMT_INTERRUPT_N_O),
    .SHARED_IRQ_LINE_D_N_O(SHARED_IRQ_LINE_D_N_O),
    .PASSTHROUGH_STATE_FLAG_O(PASSTHROUGH_STATE_FLAG_O));

// ---- kbtr_pkg.sv ----
// kbtr_pkg: offsets, field positions, reset values and state type of the keyboard port trap
// assumes: used by kbtr_gate_seq and kbtr_legacy_kbd_trap through scoped names only
package kbtr_pkg;

    // register offsets on the byte-wide register port
    localparam logic [7:0] CFG_OFFSET = 8'hC0;
    localparam logic [7:0] STATUS_OFFSET = 8'hC4;

    // configuration register fields
    localparam int CFG_EN_P60_READ = 0;
    localparam int CFG_EN_P60_WRITE = 1;
    localparam int CFG_EN_P64_READ = 2;
    localparam int CFG_EN_P64_WRITE = 3;
    localparam int CFG_IRQ_TRAP_EN = 4;
    localparam int CFG_IRQ_ROUTE_EN = 5;
    localparam int CFG_PASSTHROUGH = 6;
    localparam int CFG_SEQ_END_EN = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITABLE = 8'hBF;

    // status register fields, same positions as their enables except seq end (bit 5, its enable is bit 7)
    localparam int ST_P60_READ = 0;
    localparam int ST_P60_WRITE = 1;
    localparam int ST_P64_READ = 2;
    localparam int ST_P64_WRITE = 3;
    localparam int ST_IRQ = 4;
    localparam int ST_SEQ_END = 5;
    localparam int ST_W = 6;
    localparam logic [5:0] ST_RESET = 6'h00;

    // command and data values of the gate sequence
    localparam logic [7:0] GATE_CMD = 8'hD1;
    localparam logic [7:0] GATE_END = 8'hFF;

    // read data for an unmapped offset
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    typedef enum logic [1:0] {
        GATE_IDLE,
        GATE_SEQ_FIRST,
        GATE_SEQ_SECOND
    } kbtr_gate_t;

endpackage

// ---- tb.sv ----
// tb: register and port cycle sequences against the keyboard port trap
// assumes: host model issues port cycles; registers at C0 (config) and C4 (status)
`timescale 1ns/1ps
module tb;
    localparam logic [1:0] K60R = 2'h0, K60W = 2'h1, K64R = 2'h2, K64W = 2'h3;
    logic clk = 1'h0, rst = 1'h1, req = 1'h0, usb = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [1:0] kind = 2'h0;
    logic [7:0] dat = 8'h00, addr = 8'h00, wdat = 8'h00, adat, rdata;
    logic valid, p64, wrt, done, passed, cs_n, ready, smi_n, irq_n, flag;
    logic [1:0] ends [5] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h0};
    int num_errors = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    kbtr_host_model host (.clk_i(clk), .reset_i(rst), .req_i(req), .kind_i(kind),
        .data_i(dat), .ready_i(ready), .cs_n_i(cs_n), .valid_o(valid), .port64_o(p64),
        .write_o(wrt), .data_o(adat), .done_o(done), .passed_o(passed));
    kbtr_legacy_kbd_trap uut (.CORE_CLK_I(clk), .RESET_I(rst), .ACCESS_VALID_I(valid),
        .ACCESS_PORT64_I(p64), .ACCESS_WRITE_I(wrt), .ACCESS_DATA_I(adat), .USB_IRQ_I(usb),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .KBC_CS_N_O(cs_n), .TARGET_READY_O(ready),
        .SYSTEM_MGMT_INTERRUPT_N_O(smi_n), .SHARED_IRQ_LINE_D_N_O(irq_n),
        .PASSTHROUGH_STATE_FLAG_O(flag));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(rdata, e, "read data");
    endtask
    // one port cycle; compares select seen, interrupt and flag after it ends
    task automatic acc(input logic [1:0] k, input logic [7:0] d, input logic ps,
                       input logic sm, input logic fl);
        int i;
        @(posedge clk);
        kind <= k;
        dat <= d;
        req <= 1'h1;
        @(posedge clk);
        req <= 1'h0;
        for (i = 0; i < 10 && done !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'h1) begin
            num_errors++;
            $display("wrong value at %0t: port cycle never ended", $time);
            end_of_test();
        end
        chk({5'h00, passed, smi_n, flag}, {5'h00, ps, sm, fl}, "port cycle");
    endtask
    task automatic pins(input logic [1:0] e);
        repeat (2) @(posedge clk);
        #1 chk({6'h00, smi_n, irq_n}, {6'h00, e}, "interrupt pins");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("wrong value at %0t: run hung", $time);
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        reg_rd(8'hC0, 8'h00);
        reg_rd(8'hC4, 8'h00);
        reg_wr(8'hC0, 8'hFF);
        reg_rd(8'hC0, 8'hBF);
        reg_wr(8'h10, 8'h5A);
        reg_rd(8'h10, 8'h00);
        $display("test registers done");
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 4; k++) begin
                reg_wr(8'hC0, e ? (8'h01 << k) : 8'h00);
                acc(2'(k), 8'h33, e == 0, e == 0, 1'h0);
                reg_rd(8'hC4, 8'h01 << k);
                reg_rd(8'hC4, 8'h01 << k);
                reg_wr(8'hC4, 8'h3F);
            end
        end
        $display("test idle traps done");
        reg_wr(8'hC0, 8'h8F);
        acc(K64W, 8'hD1, 1'h1, 1'h1, 1'h1);
        reg_rd(8'hC0, 8'hCF);
        acc(K64W, 8'hD1, 1'h1, 1'h1, 1'h1);
        acc(K64R, 8'h00, 1'h0, 1'h0, 1'h1);
        reg_wr(8'hC4, 8'h3F);
        acc(K60W, 8'h42, 1'h1, 1'h1, 1'h1);
        acc(K64R, 8'h00, 1'h0, 1'h0, 1'h1);
        reg_wr(8'hC4, 8'h3F);
        acc(K64W, 8'hFF, 1'h1, 1'h0, 1'h0);
        reg_rd(8'hC4, 8'h20);
        reg_wr(8'hC4, 8'h3F);
        $display("test gate sequence done");
        for (int c = 0; c < 5; c++) begin
            acc(K64W, 8'hD1, 1'h1, 1'h1, 1'h1);
            if (c > 1) acc(K60W, 8'h42, 1'h1, 1'h1, 1'h1);
            acc(ends[c], 8'h55, 1'h0, 1'h0, 1'h0);
            reg_rd(8'hC4, 8'h20 | (8'h01 << ends[c]));
            reg_wr(8'hC4, 8'h3F);
        end
        reg_wr(8'hC0, 8'h80);
        acc(K64W, 8'hD1, 1'h1, 1'h1, 1'h1);
        acc(K60R, 8'h00, 1'h1, 1'h0, 1'h0);
        reg_rd(8'hC4, 8'h21);
        reg_wr(8'hC4, 8'h3F);
        $display("test improper ends done");
        reg_wr(8'hC0, 8'h10);
        @(posedge clk);
        usb <= 1'h1;
        pins(2'h1);
        reg_wr(8'hC0, 8'h20);
        pins(2'h2);
        @(posedge clk);
        usb <= 1'h0;
        reg_wr(8'hC4, 8'h3F);
        pins(2'h3);
        $display("test irq routing done");
        // reset from inside the gate sequence must land in idle with the flag low
        acc(K64W, 8'hD1, 1'h1, 1'h1, 1'h1);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        reg_rd(8'hC0, 8'h00);
        acc(K60W, 8'h42, 1'h1, 1'h1, 1'h0);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
